// *** hdl/spm_top.sv ***
// Shared pin mux select registers and ports A, B and C
//
// Overview of operation
// R1: Select A bits 0-3, 8-15 pick peripheral when set, port A/B pin when clear.
// R2: Select A is 16 bits, read-write, reset to zero; bits 7-4 read zero.
// R3: Select B bit 0 picks converter start; bits 4-7 pick capture inputs when set.
// R4: Select B bits 2, 3 set give port C pins 2, 3; clear give flag, branch.
// R5: Select B is 16 bits, resets zero; bits 15-8 and bit 1 are reserved.
// R6: Direction bit clear makes the pin an input; set makes it a driven output.
// R7: With direction clear, reading the data bit returns the present pin level.
// R8: With direction set, the written data bit is driven onto the pin.
// R9: Port A direction in bits 11-8, data in bits 3-0; the rest reserved.
// R10: Port B direction in bits 15-8, data in bits 7-0, bit n for pin n.
// R11: Port C direction in bits 15-8, data in bits 7-0, bit n for pin n.
// R12: Reset clears all direction and data bits; pins start as inputs.
// R13: Direction and data act only while the general-purpose function is selected.
// R14: Port C pin 1 is shared with clock output by a system control field.
// R15: With peripheral selected, it drives the pin and still sees the pin level.
// R16: Writes to reserved bits are ignored; they read back as zero.
`timescale 1ns/1ps
`default_nettype none
module spm_top
(
    input  wire logic                                sys_clk,
    input  wire logic                                reset_n,
    input  wire logic                                clk_en,
    // Data-space register access
    input  wire logic [spm_pkg::ADDR_W-1:0]          bus_addr,
    input  wire logic                                bus_wr,
    input  wire logic                                bus_rd,
    input  wire logic [spm_pkg::BUS_W-1:0]           bus_wdata,
    output logic      [spm_pkg::BUS_W-1:0]           bus_rdata,
    // Clock output sharing on port C pin 1
    input  wire logic [spm_pkg::CLOCK_OUTPUT_PIN_FIELD_W-1:0]  clock_output_pin_field,
    input  wire logic                                clock_output_src,
    // Port A
    input  wire logic [spm_pkg::PORT_A_W-1:0]        pa_pin_in,
    output logic      [spm_pkg::PORT_A_W-1:0]        pa_pin_out,
    output logic      [spm_pkg::PORT_A_W-1:0]        pa_pin_oe_n,
    input  wire logic [spm_pkg::PORT_A_W-1:0]        pa_periph_out,
    input  wire logic [spm_pkg::PORT_A_W-1:0]        pa_periph_oe,
    output logic      [spm_pkg::PORT_A_W-1:0]        pa_periph_in,
    // Port B
    input  wire logic [spm_pkg::PORT_B_W-1:0]        pb_pin_in,
    output logic      [spm_pkg::PORT_B_W-1:0]        pb_pin_out,
    output logic      [spm_pkg::PORT_B_W-1:0]        pb_pin_oe_n,
    input  wire logic [spm_pkg::PORT_B_W-1:0]        pb_periph_out,
    input  wire logic [spm_pkg::PORT_B_W-1:0]        pb_periph_oe,
    output logic      [spm_pkg::PORT_B_W-1:0]        pb_periph_in,
    // Port C
    input  wire logic [spm_pkg::PORT_C_W-1:0]        pc_pin_in,
    output logic      [spm_pkg::PORT_C_W-1:0]        pc_pin_out,
    output logic      [spm_pkg::PORT_C_W-1:0]        pc_pin_oe_n,
    input  wire logic [spm_pkg::PORT_C_W-1:0]        pc_periph_out,
    input  wire logic [spm_pkg::PORT_C_W-1:0]        pc_periph_oe,
    output logic      [spm_pkg::PORT_C_W-1:0]        pc_periph_in
);
    import spm_pkg::*;

    // ========================================
    // Helpers

    // Address match for one register
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        addr_hit = (addr == off);
    endfunction

    // Readback: driven pins return the data bit, input pins the pin level
    function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] pin);
        pin_view = (dir & dat) | (~dir & pin);
    endfunction

    // ========================================
    // Registers and decode
    logic [BUS_W-1:0] pin_select_a;
    logic [BUS_W-1:0] pin_select_b;
    logic [BUS_W-1:0] port_a_data_direction;
    logic [BUS_W-1:0] port_b_data_direction;
    logic [BUS_W-1:0] port_c_data_direction;
    logic [BUS_W-1:0] next_bus_rdata;

    wire hit_sel_a = addr_hit(bus_addr, OFF_PIN_SELECT_A);
    wire hit_sel_b = addr_hit(bus_addr, OFF_PIN_SELECT_B);
    wire hit_a     = addr_hit(bus_addr, OFF_PORT_A);
    wire hit_b     = addr_hit(bus_addr, OFF_PORT_B);
    wire hit_c     = addr_hit(bus_addr, OFF_PORT_C);
    wire wr_go     = clk_en & bus_wr;
    wire rd_go     = clk_en & bus_rd;

    // Field views
    wire [PORT_A_W-1:0] port_a_dir_bit   = port_a_data_direction[DIR_LSB +: PORT_A_W];   // R9
    wire [PORT_A_W-1:0] port_a_data_bits = port_a_data_direction[DATA_LSB +: PORT_A_W];  // R9
    wire [PORT_B_W-1:0] port_b_dir_bit   = port_b_data_direction[DIR_LSB +: PORT_B_W];   // R10
    wire [PORT_B_W-1:0] port_b_data_bits = port_b_data_direction[DATA_LSB +: PORT_B_W];  // R10
    wire [PORT_C_W-1:0] port_c_dir_bit   = port_c_data_direction[DIR_LSB +: PORT_C_W];   // R11
    wire [PORT_C_W-1:0] port_c_data_bits = port_c_data_direction[DATA_LSB +: PORT_C_W];  // R11

    // Peripheral select per pin; port C has mixed sense and the clock output
    wire [PORT_A_W-1:0] select_bit_a_pa = pin_select_a[SEL_A_PORT_A_LSB +: PORT_A_W];   // R1
    wire [PORT_B_W-1:0] select_bit_a_pb = pin_select_a[SEL_A_PORT_B_LSB +: PORT_B_W];   // R1
    wire                clock_output_pin_on       = (clock_output_pin_field != CLOCK_OUTPUT_PIN_FIELD_IO);            // R14
    wire [PORT_C_W-1:0] select_bit_b_pc =
        {pin_select_b[SEL_B_CAP_LSB +: PORT_C_W - SEL_B_CAP_LSB],                      // R3
         ~pin_select_b[SEL_B_BRANCH_BIT],                                               // R4
         ~pin_select_b[SEL_B_FLAG_BIT],                                                 // R4
         clock_output_pin_on,                                                                     // R14
         pin_select_b[SEL_B_START_BIT]};                                                // R3

    // Clock output replaces the peripheral source on port C pin 1
    wire [PORT_C_W-1:0] pc_src_out = {pc_periph_out[PORT_C_W-1:2], clock_output_src, pc_periph_out[0]};  // R14
    wire [PORT_C_W-1:0] pc_src_oe  = {pc_periph_oe[PORT_C_W-1:2], 1'b1, pc_periph_oe[0]};               // R14

    // Readback images with reserved bits forced to zero
    wire [7:0] view_a = pin_view({{(8-PORT_A_W){1'b0}}, port_a_dir_bit},
                                 {{(8-PORT_A_W){1'b0}}, port_a_data_bits},
                                 {{(8-PORT_A_W){1'b0}}, pa_pin_in});                     // R7
    wire [7:0] view_b = pin_view(port_b_dir_bit, port_b_data_bits, pb_pin_in);          // R7
    wire [7:0] view_c = pin_view(port_c_dir_bit, port_c_data_bits, pc_pin_in);          // R7

    // Read data selection; unmapped addresses read zero
    assign next_bus_rdata =
        hit_sel_a ? (pin_select_a & MASK_SEL_A) :                                       // R16
        hit_sel_b ? (pin_select_b & MASK_SEL_B) :                                       // R16
        hit_a     ? ({port_a_data_direction[15:8], view_a} & MASK_PORT_A) :             // R9
        hit_b     ? ({port_b_data_direction[15:8], view_b} & MASK_PORT_B) :
        hit_c     ? ({port_c_data_direction[15:8], view_c} & MASK_PORT_C) :
                    RDATA_RESET;

    // ========================================
    // Select registers; reserved bits never store
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pin_select_a <= REG_RESET;              // R2
            pin_select_b <= REG_RESET;              // R5
        end
        else
        begin
            if (wr_go && hit_sel_a)
                pin_select_a <= bus_wdata & MASK_SEL_A;   // R2 R16
            if (wr_go && hit_sel_b)
                pin_select_b <= bus_wdata & MASK_SEL_B;   // R5 R16
        end
    end

    // ========================================
    // Port data-and-direction registers
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            port_a_data_direction <= REG_RESET;     // R12
            port_b_data_direction <= REG_RESET;     // R12
            port_c_data_direction <= REG_RESET;     // R12
        end
        else
        begin
            if (wr_go && hit_a)
                port_a_data_direction <= bus_wdata & MASK_PORT_A;   // R9 R16
            if (wr_go && hit_b)
                port_b_data_direction <= bus_wdata & MASK_PORT_B;   // R10
            if (wr_go && hit_c)
                port_c_data_direction <= bus_wdata & MASK_PORT_C;   // R11
        end
    end

    // ========================================
    // Registered read data, held until the next read
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            bus_rdata <= RDATA_RESET;
        else if (rd_go)
            bus_rdata <= next_bus_rdata;
    end

    // ========================================
    // Pin banks
    spm_pin_bank #(.WIDTH(PORT_A_W)) u_bank_a
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .periph_sel (select_bit_a_pa),
        .dir        (port_a_dir_bit),
        .dat        (port_a_data_bits),
        .periph_out (pa_periph_out),
        .periph_oe  (pa_periph_oe),
        .pin_in     (pa_pin_in),
        .pin_out    (pa_pin_out),
        .pin_oe_n   (pa_pin_oe_n),
        .periph_in  (pa_periph_in)
    );

    spm_pin_bank #(.WIDTH(PORT_B_W)) u_bank_b
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .periph_sel (select_bit_a_pb),
        .dir        (port_b_dir_bit),
        .dat        (port_b_data_bits),
        .periph_out (pb_periph_out),
        .periph_oe  (pb_periph_oe),
        .pin_in     (pb_pin_in),
        .pin_out    (pb_pin_out),
        .pin_oe_n   (pb_pin_oe_n),
        .periph_in  (pb_periph_in)
    );

    spm_pin_bank #(.WIDTH(PORT_C_W)) u_bank_c
    (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .periph_sel (select_bit_b_pc),
        .dir        (port_c_dir_bit),
        .dat        (port_c_data_bits),
        .periph_out (pc_src_out),
        .periph_oe  (pc_src_oe),
        .pin_in     (pc_pin_in),
        .pin_out    (pc_pin_out),
        .pin_oe_n   (pc_pin_oe_n),
        .periph_in  (pc_periph_in)
    );

    // ========================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Steps of a port B pin 0 general-purpose output and a port A read
    sequence s_pb0_gpio_out;
        clk_en && !pin_select_a[SEL_A_PORT_B_LSB] && port_b_data_direction[DIR_LSB];
    endsequence

    sequence s_pb0_driven;
        !pb_pin_oe_n[0] && (pb_pin_out[0] == $past(port_b_data_direction[DATA_LSB]));
    endsequence

    sequence s_rd_a_input;
        rd_go && hit_a && !port_a_data_direction[DIR_LSB];
    endsequence

    property p_sel_a_reserved;
        pin_select_a[7:4] == 4'h0;
    endproperty
    a_sel_a_reserved: assert property (p_sel_a_reserved) else $error("select A reserved bits set");  // R2

    property p_sel_b_reserved;
        (pin_select_b[15:8] == 8'h00) && !pin_select_b[1];
    endproperty
    a_sel_b_reserved: assert property (p_sel_b_reserved) else $error("select B reserved bits set");  // R5

    property p_reset_clear;
        $rose(reset_n) |-> (port_a_data_direction == REG_RESET) && (port_b_data_direction == REG_RESET)
                           && (port_c_data_direction == REG_RESET) && (&pb_pin_oe_n);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("ports not cleared by reset");  // R12

    property p_gpio_out;
        s_pb0_gpio_out |=> s_pb0_driven;
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("port B pin 0 not driven from data");  // R8

    property p_gpio_in;
        clk_en && !pin_select_a[SEL_A_PORT_B_LSB] && !port_b_data_direction[DIR_LSB] |=> pb_pin_oe_n[0];
    endproperty
    a_gpio_in: assert property (p_gpio_in) else $error("input pin is driven");  // R6

    property p_periph_drive;
        clk_en && pin_select_a[SEL_A_PORT_B_LSB] |=>
            (pb_pin_out[0] == $past(pb_periph_out[0])) && (pb_pin_oe_n[0] == !$past(pb_periph_oe[0]));
    endproperty
    a_periph_drive: assert property (p_periph_drive) else $error("peripheral does not own pin");  // R15

    property p_inverted_flag;
        clk_en && !pin_select_b[SEL_B_FLAG_BIT] |=> pc_pin_out[2] == $past(pc_periph_out[2]);
    endproperty
    a_inverted_flag: assert property (p_inverted_flag) else $error("flag output not selected");  // R4

    property p_cap_gpio;
        clk_en && !pin_select_b[SEL_B_CAP_LSB] && port_c_data_direction[DIR_LSB + 4]
            |=> pc_pin_out[4] == $past(port_c_data_direction[DATA_LSB + 4]);
    endproperty
    a_cap_gpio: assert property (p_cap_gpio) else $error("port C pin 4 not from data");  // R3

    property p_clock_output_pin;
        clk_en && clock_output_pin_on |=> !pc_pin_oe_n[1] && (pc_pin_out[1] == $past(clock_output_src));
    endproperty
    a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock output not on port C pin 1");  // R14

    property p_read_input;
        s_rd_a_input |=> (bus_rdata[0] == $past(pa_pin_in[0])) && (bus_rdata[15:12] == 4'h0);
    endproperty
    a_read_input: assert property (p_read_input) else $error("port A read not pin level");  // R7

    property p_write_b;
        wr_go && hit_b |=> port_b_data_direction == $past(bus_wdata);
    endproperty
    a_write_b: assert property (p_write_b) else $error("port B write lost");  // R10
endmodule
`default_nettype wire

// *** inc/spm_pkg.sv ***
// Constants shared by the shared pin mux and general-purpose port block
`default_nettype none
package spm_pkg;
    // Data-space bus
    localparam int          BUS_W            = 16;
    localparam int          ADDR_W           = 16;

    // Register offsets in the data space
    localparam logic [15:0] OFF_PIN_SELECT_A = 16'h7090;
    localparam logic [15:0] OFF_PIN_SELECT_B = 16'h7092;
    localparam logic [15:0] OFF_PORT_A       = 16'h7098;
    localparam logic [15:0] OFF_PORT_B       = 16'h709A;
    localparam logic [15:0] OFF_PORT_C       = 16'h709C;

    // Implemented bits of each register; all other bits are reserved
    localparam logic [15:0] MASK_SEL_A       = 16'hFF0F;
    localparam logic [15:0] MASK_SEL_B       = 16'h00FD;
    localparam logic [15:0] MASK_PORT_A      = 16'h0F0F;
    localparam logic [15:0] MASK_PORT_B      = 16'hFFFF;
    localparam logic [15:0] MASK_PORT_C      = 16'hFFFF;

    // Reset values
    localparam logic [15:0] REG_RESET        = 16'h0000;
    localparam logic [15:0] RDATA_RESET      = 16'h0000;
    localparam logic        PIN_OUT_RESET    = 1'b0;
    localparam logic        PIN_OE_N_RESET   = 1'b1;

    // Port widths
    localparam int          PORT_A_W         = 4;
    localparam int          PORT_B_W         = 8;
    localparam int          PORT_C_W         = 8;

    // Field positions
    localparam int          DIR_LSB          = 8;
    localparam int          DATA_LSB         = 0;
    localparam int          SEL_A_PORT_A_LSB = 0;
    localparam int          SEL_A_PORT_B_LSB = 8;
    localparam int          SEL_B_START_BIT  = 0;
    localparam int          SEL_B_FLAG_BIT   = 2;
    localparam int          SEL_B_BRANCH_BIT = 3;
    localparam int          SEL_B_CAP_LSB    = 4;

    // Clock output field of the system control register
    localparam int          CLOCK_OUTPUT_PIN_FIELD_W   = 2;
    localparam logic [1:0]  CLOCK_OUTPUT_PIN_FIELD_IO  = 2'h0;
endpackage
`default_nettype wire

// *** hdl/spm_pin_bank.sv ***
// Bank of shared pin cells: peripheral or general-purpose drive per pin
`timescale 1ns/1ps
`default_nettype none
module spm_pin_bank
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] periph_sel,
    input  wire logic [WIDTH-1:0] dir,
    input  wire logic [WIDTH-1:0] dat,
    input  wire logic [WIDTH-1:0] periph_out,
    input  wire logic [WIDTH-1:0] periph_oe,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n,
    output logic      [WIDTH-1:0] periph_in
);
    import spm_pkg::*;

    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe_n;

    // ========================================
    // Per-pin source selection
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_cell
            // Port bits act only while the general-purpose function is chosen
            assign next_pin_out[i]  = periph_sel[i] ? periph_out[i] : dat[i];   // R13 R15 R8
            assign next_pin_oe_n[i] = periph_sel[i] ? ~periph_oe[i] : ~dir[i];  // R6 R15
        end
    endgenerate

    // ========================================
    // Registered pin drive; pin level always reaches the peripheral
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pin_out   <= {WIDTH{PIN_OUT_RESET}};
            pin_oe_n  <= {WIDTH{PIN_OE_N_RESET}};
            periph_in <= {WIDTH{PIN_OUT_RESET}};
        end
        else if (clk_en)
        begin
            pin_out   <= next_pin_out;
            pin_oe_n  <= next_pin_oe_n;
            periph_in <= pin_in;          // R15
        end
    end
endmodule
`default_nettype wire

// *** tb/spm_pin_model.sv ***
// Far-side model of the pins: board drivers resolved against the block's drive
`timescale 1ns/1ps
`default_nettype none
module spm_pin_model
#(
    parameter int WIDTH = 8
)
(
    input  wire logic [WIDTH-1:0] pin_out,
    input  wire logic [WIDTH-1:0] pin_oe_n,
    input  wire logic [WIDTH-1:0] ext_level,
    output logic      [WIDTH-1:0] pin_level
);
    // =====================================================
    // Wire resolution
    // Block wins where its enable is low, the board drives the rest
    assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule
`default_nettype wire

// *** tb/spm_top_test.sv ***
// Self-checking testbench of the shared pin mux and port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module spm_top_test;
    import spm_pkg::*;
    localparam int          LIMIT = 4000;
    localparam logic [15:0] OFFS [5] = '{OFF_PIN_SELECT_A, OFF_PIN_SELECT_B, OFF_PORT_A, OFF_PORT_B, OFF_PORT_C};
    localparam logic [15:0] MASKS[5] = '{MASK_SEL_A, MASK_SEL_B, MASK_PORT_A, MASK_PORT_B, MASK_PORT_C};
    logic        sys_clk;
    logic        reset_n;
    logic        clk_en;
    logic [15:0] bus_addr;
    logic        bus_wr;
    logic        bus_rd;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic [1:0]  clock_output_pin_field;
    logic        clock_output_src;
    logic [23:0] per_out;
    logic [23:0] per_oe;
    logic [23:0] ext_lvl;
    logic [23:0] pin_lvl;
    logic [23:0] g_out;
    logic [23:0] g_oen;
    logic [23:0] g_pi;
    logic [15:0] mir [5];
    logic [15:0] v;
    int          miscompares;
    int          n_compared;
    int          cycles;

    // =====================================================
    // Design and pin models
    spm_top spm_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .clock_output_pin_field(clock_output_pin_field), .clock_output_src(clock_output_src),
        .pa_pin_in(pin_lvl[3:0]), .pa_pin_out(g_out[3:0]), .pa_pin_oe_n(g_oen[3:0]),
        .pa_periph_out(per_out[3:0]), .pa_periph_oe(per_oe[3:0]), .pa_periph_in(g_pi[3:0]),
        .pb_pin_in(pin_lvl[15:8]), .pb_pin_out(g_out[15:8]), .pb_pin_oe_n(g_oen[15:8]),
        .pb_periph_out(per_out[15:8]), .pb_periph_oe(per_oe[15:8]), .pb_periph_in(g_pi[15:8]),
        .pc_pin_in(pin_lvl[23:16]), .pc_pin_out(g_out[23:16]), .pc_pin_oe_n(g_oen[23:16]),
        .pc_periph_out(per_out[23:16]), .pc_periph_oe(per_oe[23:16]), .pc_periph_in(g_pi[23:16]));
    spm_pin_model #(.WIDTH(4)) spm_pin_model_a_i (.pin_out(g_out[3:0]), .pin_oe_n(g_oen[3:0]),
        .ext_level(ext_lvl[3:0]), .pin_level(pin_lvl[3:0]));
    spm_pin_model #(.WIDTH(8)) spm_pin_model_b_i (.pin_out(g_out[15:8]), .pin_oe_n(g_oen[15:8]),
        .ext_level(ext_lvl[15:8]), .pin_level(pin_lvl[15:8]));
    spm_pin_model #(.WIDTH(8)) spm_pin_model_c_i (.pin_out(g_out[23:16]), .pin_oe_n(g_oen[23:16]),
        .ext_level(ext_lvl[23:16]), .pin_level(pin_lvl[23:16]));
    assign pin_lvl[7:4] = 4'h0;

    // =====================================================
    // Expected values
    // Pin enable and value of one port: {oe_n, out}
    function automatic logic [15:0] pins(input int p);
        logic [7:0] s;
        logic [7:0] d;
        logic [7:0] po;
        logic [7:0] oe;
        s  = (p == 0) ? {4'h0, mir[0][3:0]} : (p == 1) ? mir[0][15:8]
           : {mir[1][7:4], ~mir[1][3:2], |clock_output_pin_field, mir[1][0]};
        d  = mir[p+2][15:8];
        po = per_out[8*p +: 8];
        oe = per_oe[8*p +: 8];
        if (p == 2)
        begin
            po[1] = clock_output_src;
            oe[1] = 1'b1;
        end
        return {(s & ~oe) | (~s & ~d), (s & po) | (~s & mir[p+2][7:0])};
    endfunction

    // Level seen on the pins of one port
    function automatic logic [7:0] lvl(input int p);
        logic [15:0] e;
        e = pins(p);
        return (~e[15:8] & e[7:0]) | (e[15:8] & ext_lvl[8*p +: 8]);
    endfunction

    // Readback of one register
    function automatic logic [15:0] exp_rd(input int k);
        logic [7:0] d;
        if (k < 2)
            return mir[k];
        d = mir[k][15:8];
        return MASKS[k] & {d, (d & mir[k][7:0]) | (~d & lvl(k-2))};
    endfunction

    // =====================================================
    // Register access and checks
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd   <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic chk_regs();
        logic [15:0] r;
        for (int k = 0; k < 5; k++)
        begin
            rd(OFFS[k], r);
            `CHK(r, exp_rd(k))
        end
    endtask

    task automatic chk_pins();
        logic [15:0] e;
        logic [7:0]  w;
        for (int p = 0; p < 3; p++)
        begin
            e = pins(p);
            w = (p == 0) ? 8'h0f : 8'hff;
            `CHK(g_oen[8*p +: 8] & w, e[15:8] & w)
            `CHK(g_out[8*p +: 8] & w & ~e[15:8], e[7:0] & w & ~e[15:8])
            `CHK(g_pi[8*p +: 8] & w, lvl(p) & w)
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // =====================================================
    // Clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            give_verdict();
        end
    end

    // =====================================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h4007_f58a));
        {reset_n, bus_wr, bus_rd, clock_output_src} = 4'h0;
        clk_en = 1'b1;
        {bus_addr, bus_wdata} = 32'h0000_0000;
        clock_output_pin_field = 2'h0;
        {per_out, per_oe} = 48'h0000_0000_0000;
        ext_lvl = 24'h00_0000;
        foreach (mir[k]) mir[k] = 16'h0000;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        ext_lvl <= 24'($urandom());
        #1;
        `CHK({g_oen[23:8], g_oen[3:0]}, 20'hf_ffff)
        chk_regs();
        // Random configurations, first one all ones into reserved places
        for (int i = 0; i < 40; i++)
        begin
            for (int k = 0; k < 5; k++)
            begin
                v = (i == 0) ? 16'hffff : 16'($urandom());
                wr(OFFS[k], v);
                mir[k] = v & MASKS[k];
            end
            @(posedge sys_clk);
            per_out          <= 24'($urandom());
            per_oe           <= 24'($urandom());
            ext_lvl          <= 24'($urandom());
            clock_output_pin_field     <= 2'($urandom());
            clock_output_src <= 1'($urandom());
            repeat (3) @(posedge sys_clk);
            #1;
            chk_pins();
            chk_regs();
        end
        // Unmapped address: write ignored, read gives zero
        wr(16'h7094, 16'hffff);
        rd(16'h7094, v);
        `CHK(v, 16'h0000)
        // Write while frozen is dropped
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(OFF_PORT_B, ~mir[3]);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        chk_regs();
        // Reset in mid-run clears everything
        @(posedge sys_clk);
        reset_n <= 1'b0;
        @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        `CHK({g_oen[23:8], g_oen[3:0]}, 20'hf_ffff)
        foreach (mir[k]) mir[k] = 16'h0000;
        chk_regs();
        give_verdict();
    end
endmodule
`undef CHK
`default_nettype wire
